// file: core/hise_pkg.sv
// Purpose: Shared constants for the host indication service encoder.
// Assumes: One clock, asynchronous active-low reset, byte-wide host link.
// Notes: The core and the bench share these codes, offsets and control bit positions.
package hise_pkg;
    localparam logic [7:0] CODE_RESET = 8'h03;
    localparam logic [6:0] CODE_CONFIRM_LOW = 7'h0B;
    localparam logic [7:0] CODE_FRAME_END = 8'hCB;
    localparam logic [7:0] CODE_STOP_ENTRY = 8'h2B;
    localparam logic [7:0] CODE_HEALTH = 8'h4B;
    localparam logic [2:0] STATE_LOW = 3'h7;
    localparam logic [2:0] QUALITY_LOW = 3'h3;
    localparam logic [1:0] CONFIG_LOW = 2'h1;
    localparam logic [7:0] ACK_MASK = 8'h33;
    localparam int QUEUE_DEPTH = 4;
    localparam int QUEUE_AW = 2;
    localparam logic [31:0] ADDR_CONTROL = 32'h0000_0000;
    localparam logic [31:0] ADDR_EVENT = 32'h0000_0004;
    localparam logic [31:0] ADDR_FLAGS = 32'h0000_0008;
    localparam logic [31:0] ADDR_HEALTH = 32'h0000_000C;
    localparam int CTL_BUSY_ON = 0;
    localparam int CTL_BUSY_OFF = 1;
    localparam int CTL_RESET = 2;
    localparam int CTL_STATE_REQ = 3;
    localparam int CTL_MONITOR = 4;
    localparam int CTL_AUTO_ACK = 5;
    localparam int CTL_AUTO_POLL = 6;
    localparam int CTL_CRC = 7;
    localparam int CTL_MARKER = 8;
    localparam int CTL_HOST_ACK = 9;
    localparam int CTL_CONFIG_REQ = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
endpackage

// file: core/hise_out_queue.sv
// Purpose: Byte queue toward the host link, keeping generation order.
// Assumes: Writer pushes at most two bytes in one cycle.
// Notes: A two-byte service is pushed atomically so nothing interleaves.
`timescale 1ns/1ps
`default_nettype none
module hise_out_queue
    import hise_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic [1:0] push_count,
    input wire logic [7:0] push_first,
    input wire logic [7:0] push_second,
    output logic [2:0] free_slots,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_byte
);
    logic [7:0] slots [QUEUE_DEPTH];
    logic [QUEUE_AW-1:0] rd_ptr;
    logic [QUEUE_AW-1:0] wr_ptr;
    logic [2:0] count;
    logic pop;

    assign pop = out_valid && out_ready;
    assign out_valid = (count != 3'h0);
    assign out_byte = slots[rd_ptr];
    assign free_slots = 3'(QUEUE_DEPTH) - count;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= 3'h0;
        end else if (flush) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= 3'h0;
        end else begin
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            wr_ptr <= wr_ptr + QUEUE_AW'(push_count);
            count <= count + 3'(push_count) - 3'(pop);
        end
    end

    // Byte order inside the queue follows the order of generation.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                slots[i] <= 8'h00;
            end
        end else begin
            if (push_count != 2'h0) begin
                slots[wr_ptr] <= push_first;
            end
            if (push_count == 2'h2) begin
                slots[wr_ptr + 1'b1] <= push_second;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/hise_top.sv
// Purpose: Builds indication bytes for the host and keeps the error and busy state.
// Assumes: Event inputs are single-cycle pulses from logic on the same clock.
// Notes: Software drives requests and reads flags over AXI4-Lite.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hise_top
    import hise_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_byte_valid,
    input wire logic [7:0] bus_byte,
    input wire logic bus_frame_start,
    input wire logic tx_done,
    input wire logic tx_positive,
    input wire logic enter_normal,
    input wire logic poll_slot_collision,
    input wire logic host_byte_corrupt,
    input wire logic line_readback_mismatch,
    input wire logic command_order_fault,
    input wire logic thermal_warning,
    input wire logic frame_done,
    input wire logic parity_error,
    input wire logic checksum_error,
    input wire logic timing_error,
    input wire logic stop_entered,
    input wire logic [7:0] health_status,
    input wire logic addressed_frame,
    output logic ack_busy,
    output logic ack_positive,
    output logic host_valid,
    input wire logic host_ready,
    output logic [7:0] host_byte,
    output logic event_dropped
);
    logic [10:0] ctl_pulse;
    logic monitor_active;
    logic auto_ack_active;
    logic auto_poll_active;
    logic crc_active;
    logic marker_active;
    logic busy_mode;
    logic poll_slot_clash_flag;
    logic host_byte_fault_flag;
    logic line_mismatch_flag;
    logic command_order_fault_flag;
    logic thermal_alert_flag;
    logic flags_read;
    logic health_req;
    logic [7:0] status_byte;
    logic [1:0] next_count;
    logic [7:0] next_first;
    logic [7:0] next_second;
    logic [2:0] free_slots;
    logic [1:0] push_count;
    logic aw_hold;
    logic w_hold;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_fire;

    function automatic logic is_ack(input logic [7:0] b);
        return (b & ACK_MASK) == 8'h00;
    endfunction

    // ---------------- AXI4-Lite write path ----------------
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign write_fire = aw_hold && w_hold && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[31:2] == ADDR_CONTROL[31:2] ||
                    aw_addr[31:2] == ADDR_EVENT[31:2]) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control writes are commands: each set bit in bits 10..0 fires a one-cycle request.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_pulse <= 11'h000;
        end else if (write_fire && aw_addr[31:2] == ADDR_CONTROL[31:2]) begin
            ctl_pulse <= {w_strb[1] ? w_data[10:8] : 3'h0, w_strb[0] ? w_data[7:0] : 8'h00};
        end else begin
            ctl_pulse <= 11'h000;
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr[31:2])
                ADDR_CONTROL[31:2]: s_axi_rdata <= {26'h0, busy_mode, marker_active,
                    crc_active, auto_poll_active, auto_ack_active, monitor_active};
                ADDR_FLAGS[31:2]: s_axi_rdata <= {24'h0, poll_slot_clash_flag,
                    host_byte_fault_flag, line_mismatch_flag, command_order_fault_flag,
                    thermal_alert_flag, STATE_LOW};
                ADDR_HEALTH[31:2]: s_axi_rdata <= {24'h0, health_status};
                ADDR_EVENT[31:2]: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- Mode state ----------------
    // Features only switch on; a reset request is the only way back.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            monitor_active <= 1'b0;
            auto_ack_active <= 1'b0;
            auto_poll_active <= 1'b0;
            crc_active <= 1'b0;
            marker_active <= 1'b0;
        end else if (ctl_pulse[CTL_RESET]) begin
            monitor_active <= 1'b0;
            auto_ack_active <= 1'b0;
            auto_poll_active <= 1'b0;
            crc_active <= 1'b0;
            marker_active <= 1'b0;
        end else begin
            monitor_active <= monitor_active | ctl_pulse[CTL_MONITOR];
            auto_ack_active <= auto_ack_active | ctl_pulse[CTL_AUTO_ACK];
            auto_poll_active <= auto_poll_active | ctl_pulse[CTL_AUTO_POLL];
            crc_active <= crc_active | ctl_pulse[CTL_CRC];
            marker_active <= marker_active | ctl_pulse[CTL_MARKER];
        end
    end

    // Busy mode is only taken while auto-acknowledge runs.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_mode <= 1'b0;
        end else if (ctl_pulse[CTL_RESET] || ctl_pulse[CTL_HOST_ACK]) begin
            busy_mode <= 1'b0;
        end else if (ctl_pulse[CTL_BUSY_OFF] && auto_ack_active) begin
            busy_mode <= 1'b0;
        end else if (ctl_pulse[CTL_BUSY_ON] && auto_ack_active) begin
            busy_mode <= 1'b1;
        end
    end

    assign ack_busy = addressed_frame && auto_ack_active && busy_mode;
    assign ack_positive = addressed_frame && auto_ack_active && !busy_mode;

    // ---------------- Error flags ----------------
    // Latched flags clear on a state or reset request, but a new event in that cycle wins; the thermal flag follows its pin.
    assign flags_read = ctl_pulse[CTL_STATE_REQ] || ctl_pulse[CTL_RESET];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            poll_slot_clash_flag <= 1'b0;
            host_byte_fault_flag <= 1'b0;
            line_mismatch_flag <= 1'b0;
            command_order_fault_flag <= 1'b0;
        end else begin
            poll_slot_clash_flag <= poll_slot_collision ||
                (poll_slot_clash_flag && !flags_read);
            host_byte_fault_flag <= host_byte_corrupt ||
                (host_byte_fault_flag && !flags_read);
            line_mismatch_flag <= line_readback_mismatch ||
                (line_mismatch_flag && !flags_read);
            command_order_fault_flag <= command_order_fault ||
                (command_order_fault_flag && !flags_read);
        end
    end

    // Thermal warning is a pin-level condition, so it is synchronised first.
    logic thermal_meta;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            thermal_meta <= 1'b0;
            thermal_alert_flag <= 1'b0;
        end else begin
            thermal_meta <= thermal_warning;
            thermal_alert_flag <= thermal_meta;
        end
    end

    assign status_byte = {poll_slot_clash_flag, host_byte_fault_flag, line_mismatch_flag,
        command_order_fault_flag, thermal_alert_flag, STATE_LOW};

    // ---------------- Indication builder ----------------
    assign health_req = write_fire && aw_addr[31:2] == ADDR_EVENT[31:2] && w_strb[0]
        && w_data[0];

    // One service per cycle by fixed priority; others in that cycle are lost.
    always_comb begin
        next_count = 2'h0;
        next_first = 8'h00;
        next_second = 8'h00;
        if (bus_byte_valid && (!is_ack(bus_byte) || bus_frame_start)) begin
            next_count = 2'h1;
            next_first = bus_byte;
        end else if (bus_byte_valid && is_ack(bus_byte)) begin
            next_count = monitor_active ? 2'h1 : 2'h0;
            next_first = bus_byte;
        end else if (tx_done) begin
            next_count = 2'h1;
            next_first = {tx_positive, CODE_CONFIRM_LOW};
        end else if (enter_normal) begin
            next_count = 2'h1;
            next_first = CODE_RESET;
        end else if (ctl_pulse[CTL_STATE_REQ]) begin
            next_count = 2'h1;
            next_first = status_byte;
        end else if (frame_done && marker_active) begin
            next_count = 2'h2;
            next_first = CODE_FRAME_END;
            next_second = {parity_error, checksum_error, timing_error, 1'b1, 1'b0,
                QUALITY_LOW};
        end else if (ctl_pulse[CTL_CONFIG_REQ]) begin
            next_count = 2'h1;
            next_first = {1'b0, 1'b0, auto_ack_active, auto_poll_active, crc_active,
                marker_active, CONFIG_LOW};
        end else if (stop_entered) begin
            next_count = 2'h1;
            next_first = CODE_STOP_ENTRY;
        end else if (health_req) begin
            next_count = 2'h2;
            next_first = CODE_HEALTH;
            next_second = health_status;
        end
    end

    // A service that does not fit whole is dropped rather than split.
    assign push_count = (3'(next_count) <= free_slots) ? next_count : 2'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_dropped <= 1'b0;
        end else begin
            event_dropped <= (next_count != 2'h0) && (push_count == 2'h0);
        end
    end

    hise_out_queue u_queue (
        .clk(clk),
        .arst_n(arst_n),
        .flush(ctl_pulse[CTL_RESET]),
        .push_count(push_count),
        .push_first(next_first),
        .push_second(next_second),
        .free_slots(free_slots),
        .out_valid(host_valid),
        .out_ready(host_ready),
        .out_byte(host_byte)
    );
endmodule
`default_nettype wire

// file: tb/hise_assertions.sv
// Purpose: Port-level checks for the host indication service encoder.
// Assumes: One clock domain; only outputs of the design are judged.
// Notes: Byte checks need an empty queue, because a waiting head hides a new byte.
`timescale 1ns/1ps
`default_nettype none
module hise_assertions
    import hise_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic bus_byte_valid,
    input wire logic [7:0] bus_byte,
    input wire logic bus_frame_start,
    input wire logic tx_done,
    input wire logic tx_positive,
    input wire logic enter_normal,
    input wire logic addressed_frame,
    input wire logic ack_busy,
    input wire logic ack_positive,
    input wire logic host_valid,
    input wire logic host_ready,
    input wire logic [7:0] host_byte
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // A reset request flushes the queue while bvalid is high, so those cycles are excused.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    ack_excl_a: assert property (!(ack_busy && ack_positive))
        else $error("Busy and positive acknowledge raised together.");
    ack_addr_a: assert property ((ack_busy || ack_positive) |-> addressed_frame)
        else $error("Acknowledge raised for a frame not addressed to us.");
    data_relay_a: assert property (
        bus_byte_valid && bus_frame_start && !host_valid && !s_axi_bvalid
        |=> host_valid && host_byte == $past(bus_byte))
        else $error("Relayed frame byte differs from the bus byte.");
    confirm_code_a: assert property (
        tx_done && !bus_byte_valid && !host_valid && !s_axi_bvalid
        |=> host_valid && host_byte == {$past(tx_positive), CODE_CONFIRM_LOW})
        else $error("Transmit confirmation byte is wrong.");
    reset_ind_a: assert property (
        enter_normal && !tx_done && !bus_byte_valid && !host_valid && !s_axi_bvalid
        |=> host_valid && host_byte == CODE_RESET)
        else $error("Reset indication byte is wrong.");
    hold_head_a: assert property (
        host_valid && !host_ready && !s_axi_bvalid |=> host_valid && $stable(host_byte))
        else $error("Queue head changed while the host stalled.");
    bresp_hold_a: assert property (resp_waiting |=> s_axi_bvalid)
        else $error("Write response withdrawn before bready.");
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("Write response missing two cycles after the handshake.");
endmodule
bind hise_top hise_assertions i_hise_assertions (
    .clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte),
    .bus_frame_start(bus_frame_start), .tx_done(tx_done), .tx_positive(tx_positive),
    .enter_normal(enter_normal), .addressed_frame(addressed_frame), .ack_busy(ack_busy),
    .ack_positive(ack_positive), .host_valid(host_valid), .host_ready(host_ready),
    .host_byte(host_byte)
);
`default_nettype wire

// file: tb/hise_host_model.sv
// Purpose: Host controller that takes indication bytes from the link.
// Assumes: Same clock as the encoder.
// Notes: Slow mode drops ready every other cycle, so the head must wait.
`timescale 1ns/1ps
`default_nettype none
module hise_host_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic host_valid,
    input wire logic [7:0] host_byte,
    output logic host_ready,
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    // Bytes are taken whole, one per handshake, in arrival order.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_ready <= 1'b0;
            rx_stb <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            host_ready <= slow ? !host_ready : 1'b1;
            rx_stb <= host_valid && host_ready;
            rx_byte <= host_byte;
        end
    end
endmodule
`default_nettype wire

// file: tb/hise_top_test.sv
// Purpose: Self-checking bench for the host indication service encoder.
// Assumes: The bench plays bus receiver, transmitter and software.
// Notes: Each scenario judges its own results before it returns.
`timescale 1ns/1ps
`default_nettype none
module hise_top_test
    import hise_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, host_valid, host_ready, rx_stb, drop, busy, pos;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] host_byte, rx_byte;
    logic [9:0] ev = 10'h000;
    logic [7:0] bus_byte = 8'h00, health = 8'h00;
    logic [2:0] ferr = 3'h0;
    logic tx_pos = 1'b0, thermal = 1'b0, addressed = 1'b0, slow = 1'b0;
    logic [7:0] got_q[$];
    int miscompares = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    hise_top i_hise_top (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .bus_byte_valid(ev[0]), .bus_byte(bus_byte), .bus_frame_start(ev[1]),
        .tx_done(ev[2]), .tx_positive(tx_pos), .enter_normal(ev[3]),
        .poll_slot_collision(ev[4]), .host_byte_corrupt(ev[5]),
        .line_readback_mismatch(ev[6]), .command_order_fault(ev[7]),
        .thermal_warning(thermal), .frame_done(ev[8]), .parity_error(ferr[2]),
        .checksum_error(ferr[1]), .timing_error(ferr[0]), .stop_entered(ev[9]),
        .health_status(health), .addressed_frame(addressed), .ack_busy(busy),
        .ack_positive(pos), .host_valid(host_valid), .host_ready(host_ready),
        .host_byte(host_byte), .event_dropped(drop)
    );
    hise_host_model i_hise_host_model (
        .clk(clk), .arst_n(arst_n), .slow(slow), .host_valid(host_valid),
        .host_byte(host_byte), .host_ready(host_ready), .rx_stb(rx_stb), .rx_byte(rx_byte)
    );
    always @(posedge clk) if (rx_stb === 1'b1) got_q.push_back(rx_byte);
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic expect_byte(input logic [7:0] exp);
        int w;
        w = 0;
        while (got_q.size() == 0 && w < 100) begin
            @(posedge clk);
            w++;
        end
        check("host byte", 32'(exp), got_q.size() > 0 ? 32'(got_q.pop_front()) : 32'hDEAD);
    endtask
    task automatic expect_none();
        repeat (30) @(posedge clk);
        check("queue empty", 32'h0, 32'(got_q.size()));
    endtask
    // The extra edge keeps two pulses from being assigned in one time step.
    task automatic fire(input logic [9:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 10'h000;
        @(posedge clk);
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh;
        ah = 1'b0;
        wh = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge clk);
            ah = ah | (awvalid & awready);
            wh = wh | (wvalid & wready);
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!(ah && wh));
        bready <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while ((arvalid & arready) !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic ctl(input int b);
        logic [1:0] r;
        axw(ADDR_CONTROL, 32'h1 << b, r);
        check("control write response", 32'(RESP_OKAY), 32'(r));
    endtask
    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        check("register read", exp, d);
    endtask
    task automatic ackchk(input logic b, input logic p);
        @(negedge clk);
        check("ack busy", 32'(b), 32'(busy));
        check("ack positive", 32'(p), 32'(pos));
        @(posedge clk);
    endtask
    task automatic t_reset();
        @(negedge clk);
        check("idle host valid", 32'h0, 32'(host_valid));
        check("idle drop", 32'h0, 32'(drop));
        @(posedge clk);
        rd_check(ADDR_CONTROL, 32'h0);
    endtask
    task automatic t_relay();
        slow <= 1'b1;
        bus_byte <= 8'hBC;
        ev <= 10'h003;
        @(posedge clk);
        bus_byte <= 8'h5A;
        ev <= 10'h001;
        @(posedge clk);
        ev <= 10'h000;
        expect_byte(8'hBC);
        expect_byte(8'h5A);
        bus_byte <= 8'h10;
        fire(10'h003);
        expect_byte(8'h10);
        bus_byte <= 8'hCC;
        fire(10'h001);
        expect_none();
        slow <= 1'b0;
    endtask
    task automatic t_confirm();
        for (int p = 0; p < 2; p++) begin
            tx_pos <= p[0];
            fire(10'h004);
            expect_byte({p[0], 7'h0B});
        end
        fire(10'h008);
        expect_byte(8'h03);
    endtask
    task automatic t_flags();
        for (int i = 4; i < 8; i++) fire(10'h001 << i);
        rd_check(ADDR_FLAGS, 32'hF7);
        ctl(CTL_STATE_REQ);
        expect_byte(8'hF7);
        thermal <= 1'b1;
        repeat (6) @(posedge clk);
        ctl(CTL_STATE_REQ);
        expect_byte(8'h0F);
        thermal <= 1'b0;
        repeat (6) @(posedge clk);
        ctl(CTL_STATE_REQ);
        expect_byte(8'h07);
    endtask
    task automatic t_busy();
        addressed <= 1'b1;
        ctl(CTL_BUSY_ON);
        ackchk(1'b0, 1'b0);
        ctl(CTL_AUTO_ACK);
        ackchk(1'b0, 1'b1);
        ctl(CTL_BUSY_ON);
        ackchk(1'b1, 1'b0);
        rd_check(ADDR_CONTROL, 32'h22);
        ctl(CTL_BUSY_OFF);
        ackchk(1'b0, 1'b1);
        ctl(CTL_BUSY_ON);
        ackchk(1'b1, 1'b0);
        ctl(CTL_HOST_ACK);
        ackchk(1'b0, 1'b1);
        addressed <= 1'b0;
    endtask
    task automatic t_frames();
        logic [1:0] r;
        ctl(CTL_MARKER);
        ferr <= 3'b101;
        fire(10'h100);
        expect_byte(8'hCB);
        expect_byte(8'hB3);
        ferr <= 3'b010;
        fire(10'h100);
        expect_byte(8'hCB);
        expect_byte(8'h53);
        fire(10'h200);
        expect_byte(8'h2B);
        health <= 8'hA5;
        axw(ADDR_EVENT, 32'h1, r);
        expect_byte(8'h4B);
        expect_byte(8'hA5);
        axw(ADDR_CONTROL, 32'h0C0, r);
        ctl(CTL_CONFIG_REQ);
        expect_byte(8'h3D);
    endtask
    task automatic t_monitor();
        bus_byte <= 8'hCC;
        ctl(CTL_MONITOR);
        fire(10'h001);
        expect_byte(8'hCC);
        ctl(CTL_RESET);
        rd_check(ADDR_CONTROL, 32'h0);
        fire(10'h001);
        expect_none();
    endtask
    task automatic t_refuse();
        logic [31:0] d;
        logic [1:0] r;
        axr(32'h0000_0010, d, r);
        check("unmapped read response", 32'(RESP_SLVERR), 32'(r));
        axw(ADDR_FLAGS, 32'h0, r);
        check("read-only write response", 32'(RESP_SLVERR), 32'(r));
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_relay();
        t_confirm();
        t_flags();
        t_busy();
        t_frames();
        t_monitor();
        t_refuse();
        summarize();
    end
    initial begin
        // The run needs a few hundred cycles; far beyond that means a hang.
        repeat (30000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
